// *** thermal_alert_map.vh ***
// Register offsets, field positions, reset values and timing figures
// for the thermal alert and status logic. Definitions only.
`ifndef THERMAL_ALERT_MAP_VH
`define THERMAL_ALERT_MAP_VH

// Register offsets
`define REG_CFG1 8'h00
`define REG_CFG2 8'h01
`define REG_STAT1 8'h02
`define REG_STAT2 8'h03
`define REG_LOC_LOW 8'h10
`define REG_LOC_HIGH 8'h11
`define REG_LOC_OT 8'h12
`define REG_REM_LOW 8'h13
`define REG_REM_HIGH 8'h14
`define REG_REM_OT 8'h15
`define REG_OT_BEHAV 8'h3F

// First status register bits
`define S1_ALARM 0
`define S1_FANFLT 1
`define S1_RHIGH 2
`define S1_RLOW 3
`define S1_ROT 4
`define S1_DIODE 5
`define S1_LHIGH 6
`define S1_LLOW 7
`define S1_CLR_MASK 8'hDF
`define S1_ALERT_MASK 8'hDF

// Second status register bits
`define S2_LOT 6
`define S2_EXT 7
`define S2_CLR_MASK 8'hC0

// Interrupt enable bits in the second config register
`define EN_LOCAL 0
`define EN_REMOTE 1
`define EN_FAN 2

// Boost enable bit in the overtemp behaviour register
`define OT_BOOST 7

// Fan operating mode field in the first config register
`define MODE_LSB 0
`define MODE_AUTO 2'h0
`define MODE_FILTERED 2'h1
`define MODE_DUTY 2'h2
`define MODE_RPM 2'h3

// Reset values
`define CFG1_RST 8'h00
`define CFG2_RST 8'h07
`define LOW_RST 8'h00
`define HIGH_RST 8'h46
`define OT_RST 8'h50
`define BOOST_RST 1'h0
`define REV_CODE 4'h1

// Overtemp hysteresis in degrees, one degree per LSB
`define OT_HYST_C 9'h005

// Address pin three-level codes
`define ADDR_LOW 2'h0
`define ADDR_FLOAT 2'h1
`define ADDR_HIGH 2'h2
`define ADDR_SETTLE 2'h2

// External pull-down masking depth after own drive
`define OWN_DRIVE_HIST 3

`endif

// *** limit_channel.v ***
// One temperature channel compared against low, high and overtemp limits.
// Assumes temperatures and limits are signed 8-bit, 1 degree per LSB,
// and a one-cycle monitoring tick from the conversion logic.
`timescale 1ns/1ps
`include "thermal_alert_map.vh"

module limit_channel #(
  parameter W = 8
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Monitoring cycle and samples
  input wire tick_i,
  input wire [W-1:0] temp_i,
  input wire [W-1:0] low_lim_i,
  input wire [W-1:0] high_lim_i,
  input wire [W-1:0] ot_lim_i,
  // Results
  output reg high_o,
  output reg low_o,
  output reg ot_act_o,
  output reg ot_rise_o
);

  wire signed [W:0] temp_s;
  wire signed [W:0] ot_s;
  wire signed [W:0] ot_rel_s;

  assign temp_s = {temp_i[W-1], temp_i};
  assign ot_s = {ot_lim_i[W-1], ot_lim_i};
  assign ot_rel_s = ot_s - $signed(`OT_HYST_C);

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      high_o <= 1'b0;
      low_o <= 1'b0;
      ot_act_o <= 1'b0;
      ot_rise_o <= 1'b0;
    end else begin
      ot_rise_o <= 1'b0;
      if (tick_i) begin
        // Limits compared as signed, like the temperatures
        high_o <= (temp_s > $signed({high_lim_i[W-1], high_lim_i})); // R3
        low_o <= (temp_s < $signed({low_lim_i[W-1], low_lim_i})); // R2
        if (!ot_act_o && (temp_s > ot_s)) begin
          ot_act_o <= 1'b1; // R4
          ot_rise_o <= 1'b1; // R19
        end else if (ot_act_o && (temp_s < ot_rel_s)) begin
          ot_act_o <= 1'b0; // R18
        end
      end
    end
  end

endmodule // limit_channel

// *** thermal_alert_status.v ***
// Alarm, alert and status logic of a temperature monitor and fan controller.
// Assumes the serial bus slave gives one-cycle register strobes on clk_i,
// conversion logic gives temperatures and a monitoring tick on clk_i.
`timescale 1ns/1ps
`include "thermal_alert_map.vh"

// What this block does
// [R1] Sample address pin once, fix address bits
// [R2] Alert low when temperature below low limit
// [R3] Alert low when temperature above high limit
// [R4] Overtemp pin low above limit, never masked
// [R5] Own overtemp drive boosts fan if enabled
// [R6] External pull-down sets flag, always boosts fan
// [R7] Cleared enable clears and blocks channel interrupts
// [R8] Fan alarm and fault flags clear on read
// [R9] Alarm flag resets only after leaving alarm speed
// [R10] Fan fault flag sets on every failure
// [R11] Remote high/low flags clear, reassert each cycle
// [R12] Local high/low flags clear, reassert each cycle
// [R13] Remote overtemp flag sets, clears on read
// [R14] Diode fault at power-up sticks, never clears
// [R15] Local overtemp flag sets, clears on read
// [R16] External pull-down flag clears on read
// [R17] Overtemp drives both alert and overtemp pin
// [R18] Read releases alert; pin holds until 5 below
// [R19] Overtemp alert rearms 5 degrees below limit
// [R20] Four fan operating modes selectable
// [R21] Alert response ack releases, reasserts next cycle
// [R22] Host reads status registers to clear alert
module thermal_alert_status #(
  parameter W = 8
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Register access from serial bus slave
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  // Alert response address acknowledge
  input wire ara_ack_i,
  // Measurement side
  input wire mon_tick_i,
  input wire [W-1:0] local_temp_i,
  input wire [W-1:0] remote_temp_i,
  input wire diode_fault_i,
  input wire fan_alarm_speed_i,
  input wire tach_fail_i,
  // Address select pin, three-level code
  input wire [1:0] addr_pin_i,
  output reg [1:0] bus_addr_lsb_o,
  // Overtemp open-drain pin
  input wire overtemp_pin_n_i,
  output reg overtemp_pin_n_o,
  output reg overtemp_pin_n_oe_o,
  // Alert and fan control
  output reg alert_n_o,
  output reg fan_full_o,
  output reg [1:0] fan_mode_o
);

  reg [7:0] cfg1_ff;
  reg [7:0] cfg2_ff;
  reg [7:0] stat1_ff;
  reg [7:0] stat2_ff;
  reg [W-1:0] loc_low_ff;
  reg [W-1:0] loc_high_ff;
  reg [W-1:0] loc_ot_ff;
  reg [W-1:0] rem_low_ff;
  reg [W-1:0] rem_high_ff;
  reg [W-1:0] rem_ot_ff;
  reg boost_ff;
  reg alarm_arm_ff;
  reg alert_act_ff;
  reg first_tick_ff;
  reg ot_s1_ff;
  reg ot_s2_ff;
  reg [1:0] addr_s1_ff;
  reg [1:0] addr_s2_ff;
  reg [1:0] addr_cnt_ff;
  reg addr_done_ff;
  reg [`OWN_DRIVE_HIST-1:0] drive_hist_ff;

  reg [7:0] nxt_stat1;
  reg [7:0] nxt_stat2;
  reg [7:0] set1;
  reg [7:0] set2;
  reg [7:0] en1;
  reg [7:0] en2;
  reg nxt_alert_act;
  reg [7:0] rd_mux;

  wire loc_high;
  wire loc_low;
  wire loc_ot;
  wire loc_ot_rise;
  wire rem_high;
  wire rem_low;
  wire rem_ot;
  wire rem_ot_rise;
  wire en_loc;
  wire en_rem;
  wire en_fan;
  wire rd_stat1;
  wire rd_stat2;
  wire own_drive;
  wire ext_low;
  wire alarm_set;
  wire pending;
  wire new_event;

  function wr_hit;
    input [7:0] addr;
    input [7:0] target;
    input strobe;
    begin
      wr_hit = strobe && (addr == target);
    end
  endfunction

  assign en_loc = cfg2_ff[`EN_LOCAL];
  assign en_rem = cfg2_ff[`EN_REMOTE];
  assign en_fan = cfg2_ff[`EN_FAN];
  assign rd_stat1 = wr_hit(reg_addr_i, `REG_STAT1, reg_rd_i);
  assign rd_stat2 = wr_hit(reg_addr_i, `REG_STAT2, reg_rd_i);
  assign own_drive = loc_ot | rem_ot;
  // Own drive is masked while it may still echo through the synchroniser
  assign ext_low = !ot_s2_ff && !(|drive_hist_ff) && !overtemp_pin_n_oe_o;
  assign alarm_set = fan_full_o && alarm_arm_ff; // R9
  assign pending = (|(stat1_ff & `S1_ALERT_MASK)) | (|stat2_ff);
  assign new_event = |((set1 & en1 & `S1_ALERT_MASK) | (set2 & en2));

  limit_channel #(.W(W)) u_local (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(mon_tick_i),
    .temp_i(local_temp_i),
    .low_lim_i(loc_low_ff),
    .high_lim_i(loc_high_ff),
    .ot_lim_i(loc_ot_ff),
    .high_o(loc_high),
    .low_o(loc_low),
    .ot_act_o(loc_ot),
    .ot_rise_o(loc_ot_rise)
  );

  limit_channel #(.W(W)) u_remote (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(mon_tick_i),
    .temp_i(remote_temp_i),
    .low_lim_i(rem_low_ff),
    .high_lim_i(rem_high_ff),
    .ot_lim_i(rem_ot_ff),
    .high_o(rem_high),
    .low_o(rem_low),
    .ot_act_o(rem_ot),
    .ot_rise_o(rem_ot_rise)
  );

  // Status set, clear and enable masks; set wins over clear
  always @* begin
    set1 = 8'h00;
    set1[`S1_ALARM] = alarm_set;
    set1[`S1_FANFLT] = tach_fail_i; // R10
    set1[`S1_RHIGH] = mon_tick_i && rem_high; // R11
    set1[`S1_RLOW] = mon_tick_i && rem_low; // R11
    set1[`S1_ROT] = rem_ot_rise; // R13
    set1[`S1_DIODE] = first_tick_ff && mon_tick_i && diode_fault_i; // R14
    set1[`S1_LHIGH] = mon_tick_i && loc_high; // R12
    set1[`S1_LLOW] = mon_tick_i && loc_low; // R12
    set2 = 8'h00;
    set2[`S2_LOT] = loc_ot_rise; // R15
    set2[`S2_EXT] = ext_low; // R6
    en1 = {en_loc, en_loc, 1'b1, en_rem, en_rem, en_rem, en_fan, en_fan}; // R7
    en2 = {1'b1, en_loc, 6'h00}; // R7
    nxt_stat1 = ((stat1_ff & ~(rd_stat1 ? `S1_CLR_MASK : 8'h00)) | set1) & en1; // R8
    nxt_stat2 = ((stat2_ff & ~(rd_stat2 ? `S2_CLR_MASK : 8'h00)) | set2) & en2; // R16
  end

  // Alert latch: new events assert, ack or empty status releases
  always @* begin
    if (new_event) begin
      nxt_alert_act = 1'b1; // R17
    end else if (ara_ack_i) begin
      nxt_alert_act = 1'b0; // R21
    end else if (mon_tick_i && pending) begin
      nxt_alert_act = 1'b1; // R21
    end else if (!pending) begin
      nxt_alert_act = 1'b0; // R18
    end else begin
      nxt_alert_act = alert_act_ff;
    end
  end

  // Read data
  always @* begin
    case (reg_addr_i)
      `REG_CFG1: rd_mux = cfg1_ff;
      `REG_CFG2: rd_mux = cfg2_ff;
      `REG_STAT1: rd_mux = stat1_ff;
      `REG_STAT2: rd_mux = stat2_ff;
      `REG_LOC_LOW: rd_mux = loc_low_ff;
      `REG_LOC_HIGH: rd_mux = loc_high_ff;
      `REG_LOC_OT: rd_mux = loc_ot_ff;
      `REG_REM_LOW: rd_mux = rem_low_ff;
      `REG_REM_HIGH: rd_mux = rem_high_ff;
      `REG_REM_OT: rd_mux = rem_ot_ff;
      `REG_OT_BEHAV: rd_mux = {boost_ff, 3'h0, `REV_CODE};
      default: rd_mux = 8'h00;
    endcase
  end

  // Writable registers
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg1_ff <= `CFG1_RST;
      cfg2_ff <= `CFG2_RST;
      loc_low_ff <= `LOW_RST;
      loc_high_ff <= `HIGH_RST;
      loc_ot_ff <= `OT_RST;
      rem_low_ff <= `LOW_RST;
      rem_high_ff <= `HIGH_RST;
      rem_ot_ff <= `OT_RST;
      boost_ff <= `BOOST_RST;
      fan_mode_o <= `MODE_AUTO;
      reg_rdata_o <= 8'h00;
    end else begin
      if (wr_hit(reg_addr_i, `REG_CFG1, reg_wr_i)) begin
        cfg1_ff <= reg_wdata_i;
      end
      if (wr_hit(reg_addr_i, `REG_CFG2, reg_wr_i)) begin
        cfg2_ff <= reg_wdata_i;
      end
      if (wr_hit(reg_addr_i, `REG_LOC_LOW, reg_wr_i)) begin
        loc_low_ff <= reg_wdata_i[W-1:0];
      end
      if (wr_hit(reg_addr_i, `REG_LOC_HIGH, reg_wr_i)) begin
        loc_high_ff <= reg_wdata_i[W-1:0];
      end
      if (wr_hit(reg_addr_i, `REG_LOC_OT, reg_wr_i)) begin
        loc_ot_ff <= reg_wdata_i[W-1:0];
      end
      if (wr_hit(reg_addr_i, `REG_REM_LOW, reg_wr_i)) begin
        rem_low_ff <= reg_wdata_i[W-1:0];
      end
      if (wr_hit(reg_addr_i, `REG_REM_HIGH, reg_wr_i)) begin
        rem_high_ff <= reg_wdata_i[W-1:0];
      end
      if (wr_hit(reg_addr_i, `REG_REM_OT, reg_wr_i)) begin
        rem_ot_ff <= reg_wdata_i[W-1:0];
      end
      if (wr_hit(reg_addr_i, `REG_OT_BEHAV, reg_wr_i)) begin
        boost_ff <= reg_wdata_i[`OT_BOOST];
      end
      fan_mode_o <= cfg1_ff[`MODE_LSB+1:`MODE_LSB]; // R20
      if (reg_rd_i) begin
        reg_rdata_o <= rd_mux;
      end
    end
  end

  // Status, alert, pin and fan state
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stat1_ff <= 8'h00;
      stat2_ff <= 8'h00;
      alarm_arm_ff <= 1'b1;
      alert_act_ff <= 1'b0;
      alert_n_o <= 1'b1;
      first_tick_ff <= 1'b1;
      ot_s1_ff <= 1'b1;
      ot_s2_ff <= 1'b1;
      drive_hist_ff <= {`OWN_DRIVE_HIST{1'b0}};
      overtemp_pin_n_o <= 1'b0;
      overtemp_pin_n_oe_o <= 1'b0;
      fan_full_o <= 1'b0;
    end else begin
      stat1_ff <= nxt_stat1;
      stat2_ff <= nxt_stat2;
      if (alarm_set) begin
        alarm_arm_ff <= 1'b0;
      end else if (!fan_full_o) begin
        alarm_arm_ff <= 1'b1; // R9
      end
      if (mon_tick_i) begin
        first_tick_ff <= 1'b0;
      end
      alert_act_ff <= nxt_alert_act;
      alert_n_o <= !nxt_alert_act; // R2 R3
      ot_s1_ff <= overtemp_pin_n_i;
      ot_s2_ff <= ot_s1_ff;
      drive_hist_ff <= {drive_hist_ff[`OWN_DRIVE_HIST-2:0], overtemp_pin_n_oe_o};
      overtemp_pin_n_o <= 1'b0;
      overtemp_pin_n_oe_o <= own_drive; // R4 R17
      fan_full_o <= (overtemp_pin_n_oe_o && boost_ff) || ext_low; // R5 R6
    end
  end

  // Address pin captured once after reset release
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_s1_ff <= `ADDR_FLOAT;
      addr_s2_ff <= `ADDR_FLOAT;
      addr_cnt_ff <= 2'h0;
      addr_done_ff <= 1'b0;
      bus_addr_lsb_o <= `ADDR_FLOAT;
    end else begin
      addr_s1_ff <= addr_pin_i;
      addr_s2_ff <= addr_s1_ff;
      if (!addr_done_ff) begin
        if (addr_cnt_ff == `ADDR_SETTLE) begin
          addr_done_ff <= 1'b1;
          bus_addr_lsb_o <= (addr_s2_ff == `ADDR_HIGH) ? `ADDR_HIGH :
                            (addr_s2_ff == `ADDR_LOW) ? `ADDR_LOW : `ADDR_FLOAT; // R1
        end else begin
          addr_cnt_ff <= addr_cnt_ff + 2'h1;
        end
      end
    end
  end

endmodule // thermal_alert_status

// *** thermal_alert_status_sva.sv ***
// Checker for the thermal alert and status block.
// Assumes the block's own top-level ports; bound after the module.
`timescale 1ns/1ps
module thermal_alert_status_sva (
  // Clock, reset, register port
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  // Events and pins
  input wire ara_ack_i,
  input wire mon_tick_i,
  input wire tach_fail_i,
  input wire [1:0] bus_addr_lsb_o,
  input wire overtemp_pin_n_i,
  input wire overtemp_pin_n_o,
  input wire overtemp_pin_n_oe_o,
  input wire alert_n_o,
  input wire fan_full_o,
  input wire [1:0] fan_mode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  reg [2:0] cnt_ff;
  reg boost_ff;
  reg [1:0] mode_ff;
  // Shadows of boost bit and mode field
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= 3'h0;
      boost_ff <= 1'h0;
      mode_ff <= 2'h0;
    end else begin
      if (cnt_ff != 3'h5) cnt_ff <= cnt_ff + 3'h1;
      if (reg_wr_i && reg_addr_i == 8'h3F) boost_ff <= reg_wdata_i[7];
      if (reg_wr_i && reg_addr_i == 8'h00) mode_ff <= reg_wdata_i[1:0];
    end
  end
  sequence quiet_ack;
    ara_ack_i && !mon_tick_i && !$past(mon_tick_i) && !$past(mon_tick_i, 2) && !tach_fail_i
      && !fan_full_o && $past(overtemp_pin_n_i, 2);
  endsequence
  sequence ext_pull;
    (!overtemp_pin_n_i && !overtemp_pin_n_oe_o) [*3];
  endsequence
  a_pin_drive_low: assert property (overtemp_pin_n_oe_o |-> !overtemp_pin_n_o)
    else $error("overtemp pin driven high");
  a_oe_after_tick: assert property ($rose(overtemp_pin_n_oe_o) |-> $past(mon_tick_i, 2))
    else $error("overtemp drive without tick");
  a_own_boost: assert property ($rose(overtemp_pin_n_oe_o) && boost_ff |-> ##[0:2] fan_full_o)
    else $error("no boost on own drive");
  a_ext_boost: assert property (ext_pull |-> ##[0:6] fan_full_o)
    else $error("no boost on external pull");
  a_ack_release: assert property (quiet_ack |=> alert_n_o)
    else $error("alert held after ack");
  a_addr_fixed: assert property (cnt_ff == 3'h5 |-> $stable(bus_addr_lsb_o))
    else $error("address bits changed");
  a_mode_copy: assert property (reg_wr_i && reg_addr_i == 8'h00 |-> ##2 fan_mode_o == mode_ff)
    else $error("mode not applied");
  a_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 8'h20 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
endmodule // thermal_alert_status_sva
bind thermal_alert_status thermal_alert_status_sva i_sva (
  .clk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o,
  .ara_ack_i, .mon_tick_i, .tach_fail_i, .bus_addr_lsb_o, .overtemp_pin_n_i,
  .overtemp_pin_n_o, .overtemp_pin_n_oe_o, .alert_n_o, .fan_full_o, .fan_mode_o
);

// *** host_model.sv ***
// Host model: reads both status registers once the alert falls.
// Assumes one-cycle read strobes, data visible the cycle after.
`timescale 1ns/1ps
module host_model (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Alert and read data
  input wire en_i,
  input wire alert_n_i,
  input wire [7:0] rdata_i,
  // Read request
  output reg rd_o,
  output reg [7:0] addr_o,
  // Captured status
  output reg [7:0] s1_o,
  output reg [7:0] s2_o
);
  reg [2:0] st_ff;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= 3'h0;
      rd_o <= 1'h0;
      addr_o <= 8'h00;
      s1_o <= 8'h00;
      s2_o <= 8'h00;
    end else begin
      case (st_ff)
        3'h0: begin
          rd_o <= en_i && !alert_n_i;
          addr_o <= 8'h02;
        end
        3'h1: addr_o <= 8'h03;
        3'h2: begin
          rd_o <= 1'h0;
          s1_o <= rdata_i;
        end
        3'h3: s2_o <= rdata_i;
        // Released address wanders
        default: addr_o <= ~addr_o;
      endcase
      if (st_ff != 3'h0 || (en_i && !alert_n_i)) st_ff <= st_ff + 3'h1;
    end
  end
endmodule // host_model

// *** tb_thermal_alert_status.sv ***
// Testbench for the thermal alert and status block.
// Assumes the host model and checker compile before it.
`timescale 1ns/1ps
module tb_thermal_alert_status;
  reg clk_i = 1'h0, rst_i = 1'h1;
  reg wr = 1'h0, trd = 1'h0, ack = 1'h0, tick = 1'h0;
  reg dflt = 1'h1, tach = 1'h0, ext = 1'h0, hen = 1'h0;
  reg [7:0] ta = 8'h00, wd = 8'h00, lt = 8'h14, rt = 8'h14, d;
  reg [1:0] apin = 2'h2;
  reg [23:0] rows [0:5];
  int bad_count = 0, compares = 0, i;
  wire [7:0] rdata, haddr, hs1, hs2;
  wire [1:0] lsb, mode;
  wire hrd, pin_o, oe, alert_n, fan_full;
  // Open-drain pin with pull-up
  wire pin = ~((oe & ~pin_o) | ext);
  wire [7:0] addr = hrd ? haddr : ta;
  thermal_alert_status i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(trd | hrd), .reg_wdata_i(wd), .reg_rdata_o(rdata), .ara_ack_i(ack),
    .mon_tick_i(tick), .local_temp_i(lt), .remote_temp_i(rt), .diode_fault_i(dflt),
    .fan_alarm_speed_i(1'h0), .tach_fail_i(tach), .addr_pin_i(apin),
    .bus_addr_lsb_o(lsb), .overtemp_pin_n_i(pin), .overtemp_pin_n_o(pin_o),
    .overtemp_pin_n_oe_o(oe), .alert_n_o(alert_n), .fan_full_o(fan_full),
    .fan_mode_o(mode)
  );
  host_model i_host (
    .clk_i(clk_i), .rst_i(rst_i), .en_i(hen), .alert_n_i(alert_n), .rdata_i(rdata),
    .rd_o(hrd), .addr_o(haddr), .s1_o(hs1), .s2_o(hs2)
  );
  always #20 clk_i = ~clk_i;
  task chk(input string nm, input [7:0] seen, input [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task wreg(input [7:0] a, input [7:0] v);
    @(posedge clk_i);
    wr <= 1'h1;
    ta <= a;
    wd <= v;
    @(posedge clk_i);
    wr <= 1'h0;
  endtask
  task rc(input [7:0] a, input [7:0] e);
    @(posedge clk_i);
    trd <= 1'h1;
    ta <= a;
    @(posedge clk_i);
    trd <= 1'h0;
    @(posedge clk_i);
    d = rdata;
    chk($sformatf("reg %h", a), d, e);
  endtask
  task tk(input [7:0] l, input [7:0] r, input int n);
    repeat (n) begin
      @(posedge clk_i);
      lt <= l;
      rt <= r;
      tick <= 1'h1;
      @(posedge clk_i);
      tick <= 1'h0;
    end
    cyc(4);
  endtask
  task tp;
    @(posedge clk_i) tach <= 1'h1;
    @(posedge clk_i) tach <= 1'h0;
    cyc(3);
  endtask
  task tally_and_finish;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Cut-off about twenty times the expected run
  initial begin
    #400000;
    bad_count++;
    tally_and_finish;
  end
  initial begin
    rows[0] = 24'h141420;
    rows[1] = 24'h471460;
    rows[2] = 24'hFF14A0;
    rows[3] = 24'h144724;
    rows[4] = 24'h14FF28;
    rows[5] = 24'h145134;
    cyc(6);
    chk("alert", alert_n, 8'h01);
    chk("oe", oe, 8'h00);
    cyc(6);
    rst_i <= 1'h0;
    cyc(6);
    chk("addr", lsb, 8'h02);
    rc(8'h01, 8'h07);
    rc(8'h3F, 8'h01);
    rc(8'h20, 8'h00);
    $display("end reset");
    for (i = 0; i < 6; i++) begin
      tk(8'h14, 8'h14, 2);
      // First idle tick still reports the previous row's high/low results
      rc(8'h02, (i == 0) ? 8'h20 : (rows[i - 1][7:0] & 8'hEF));
      tk(rows[i][23:16], rows[i][15:8], 2);
      chk("alert", alert_n, {7'h00, (rows[i][7:0] & 8'hDF) == 8'h00});
      chk("oe", oe, {7'h00, rows[i][4]});
      chk("fan", fan_full, 8'h00);
      rc(8'h02, rows[i][7:0]);
      rc(8'h02, 8'h20);
      tk(rows[i][23:16], rows[i][15:8], 1);
      rc(8'h02, rows[i][7:0] & 8'hEF);
    end
    $display("end rows");
    tk(8'h14, 8'h4C, 2);
    chk("oe", oe, 8'h01);
    chk("pin", pin_o, 8'h00);
    tk(8'h14, 8'h4A, 2);
    chk("oe", oe, 8'h00);
    rc(8'h02, 8'h24);
    wreg(8'h3F, 8'h80);
    rc(8'h3F, 8'h81);
    tk(8'h14, 8'h51, 2);
    chk("fan", fan_full, 8'h01);
    chk("alert", alert_n, 8'h00);
    rc(8'h02, 8'h35);
    rc(8'h02, 8'h20);
    tk(8'h14, 8'h51, 1);
    rc(8'h02, 8'h24);
    tk(8'h14, 8'h14, 2);
    chk("fan", fan_full, 8'h00);
    rc(8'h02, 8'h24);
    $display("end overtemp");
    wreg(8'h3F, 8'h00);
    @(posedge clk_i) ext <= 1'h1;
    cyc(8);
    chk("fan", fan_full, 8'h01);
    @(posedge clk_i) ext <= 1'h0;
    cyc(6);
    rc(8'h03, 8'h80);
    rc(8'h03, 8'h00);
    rc(8'h02, 8'h21);
    tk(8'h51, 8'h14, 2);
    chk("fan", fan_full, 8'h00);
    rc(8'h03, 8'h40);
    rc(8'h03, 8'h00);
    tk(8'h14, 8'h14, 2);
    rc(8'h02, 8'h60);
    $display("end pin");
    tk(8'h47, 8'h14, 2);
    chk("alert", alert_n, 8'h00);
    wreg(8'h01, 8'h06);
    cyc(3);
    chk("alert", alert_n, 8'h01);
    rc(8'h02, 8'h20);
    tk(8'h47, 8'h14, 2);
    chk("alert", alert_n, 8'h01);
    wreg(8'h01, 8'h07);
    tk(8'h47, 8'h14, 2);
    @(posedge clk_i) ack <= 1'h1;
    @(posedge clk_i) ack <= 1'h0;
    cyc(2);
    chk("alert", alert_n, 8'h01);
    tk(8'h47, 8'h14, 1);
    chk("alert", alert_n, 8'h00);
    tk(8'h14, 8'h14, 2);
    rc(8'h02, 8'h60);
    $display("end mask");
    tp;
    rc(8'h02, 8'h22);
    rc(8'h02, 8'h20);
    tp;
    rc(8'h02, 8'h22);
    wreg(8'h02, 8'hFF);
    rc(8'h02, 8'h20);
    for (i = 0; i < 4; i++) begin
      wreg(8'h00, i[7:0]);
      cyc(2);
      chk("mode", mode, i[7:0]);
    end
    $display("end tach");
    hen <= 1'h1;
    tk(8'h14, 8'h47, 2);
    cyc(12);
    chk("host", hs1, 8'h24);
    chk("host", hs2, 8'h00);
    chk("alert", alert_n, 8'h01);
    apin <= 2'h0;
    cyc(4);
    chk("addr", lsb, 8'h02);
    $display("end host");
    tally_and_finish;
  end
endmodule // tb_thermal_alert_status
